// file: hw/lp_ability_reg.v
// Link partner ability register with page-received flag
`include "lp_ability_defines.vh"
module lp_ability_reg
(
  input wire clk_sys,
  input wire rst_b,
  input wire [15:0] rx_word,
  input wire rx_word_valid,
  input wire override_writable,
  input wire [4:0] mgmt_addr,
  input wire mgmt_rd,
  input wire mgmt_wr,
  input wire [15:0] mgmt_wdata,
  output wire [15:0] mgmt_rdata,
  output wire page_received,
  output wire [1:0] selector_kind,
  output wire selector_supported
);
  // Stored partner word and the registered outputs, each with its next value
  reg [15:0] lpa_r;
  reg [15:0] lpa_nxt;
  reg [15:0] rdata_r;
  reg [15:0] rdata_nxt;
  reg [1:0] sel_kind_r;
  reg [1:0] sel_kind_nxt;
  reg [15:0] wr_merge;
  reg [15:0] rd_view;
  reg [15:0] xpn_view;

  // Received word taken apart field by field
  wire rx_next_page;
  wire rx_ack;
  wire rx_remote_fault;
  wire [2:0] rx_reserved;
  wire rx_t4;
  wire [3:0] advertised_tech_field;
  wire [4:0] rx_selector;
  wire [15:0] rx_fields;

  // Management decode
  wire lpa_hit;
  wire xpn_hit;
  wire lpa_read;
  wire xpn_read;
  wire lpa_write;
  wire word_stored;

  // Address match, shared by the two registers this block answers
  function addr_hit;
    input [4:0] addr;
    input [4:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // Only two selector codes are defined; everything else decodes as none
  function [1:0] sel_decode;
    input [4:0] sel;
    begin
      case (sel)
        `SEL_8023:
        begin
          sel_decode = `SEL_IS_8023;
        end
        `SEL_8029:
        begin
          sel_decode = `SEL_IS_8029;
        end
        default:
        begin
          sel_decode = `SEL_NONE;
        end
      endcase
    end
  endfunction

  // Field split keeps each partner capability in its own bit range
  assign rx_next_page = rx_word[`LPA_NEXT_PAGE];
  assign rx_ack = rx_word[`LPA_ACK];
  assign rx_remote_fault = rx_word[`LPA_REMOTE_FAULT];
  assign rx_reserved = rx_word[`LPA_RSVD_HI:`LPA_RSVD_LO];
  assign rx_t4 = rx_word[`LPA_T4];
  assign advertised_tech_field = rx_word[`LPA_TAF_HI:`LPA_TAF_LO];
  assign rx_selector = rx_word[`LPA_SEL_HI:`LPA_SEL_LO];
  // Reserved and T4 bits are kept as received; only the read path hides them
  assign rx_fields = {rx_next_page, rx_ack, rx_remote_fault, rx_reserved, rx_t4,
    advertised_tech_field, rx_selector};

  assign lpa_hit = addr_hit(mgmt_addr, `LPA_ADDR);
  assign xpn_hit = addr_hit(mgmt_addr, `XPN_ADDR);
  assign lpa_read = mgmt_rd && lpa_hit;
  assign xpn_read = mgmt_rd && xpn_hit;
  assign lpa_write = mgmt_wr && lpa_hit && override_writable;
  // One pulse moves the register and the page flag together
  assign word_stored = rx_word_valid;

  // Bit 4 and above keep their received value; only bits 3:0 take write data
  always @*
  begin
    wr_merge = lpa_r;
    wr_merge[`LPA_SEL_CW_HI:`LPA_SEL_LO] = mgmt_wdata[`LPA_SEL_CW_HI:`LPA_SEL_LO];
  end

  // A received word wins over a write in the same cycle, so no page is half overwritten
  always @*
  begin
    lpa_nxt = lpa_r;
    if (word_stored)
    begin
      lpa_nxt = rx_fields;
    end
    else if (lpa_write)
    begin
      lpa_nxt = wr_merge;
    end
  end

  // All sixteen bits load on one edge, so a read never mixes two pages
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      lpa_r <= `LPA_RESET;
    end
    else
    begin
      lpa_r <= lpa_nxt;
    end
  end

  // T4 and reserved bits forced to zero on the read path
  always @*
  begin
    rd_view = lpa_r;
    rd_view[`LPA_RSVD_HI:`LPA_RSVD_LO] = `LPA_RSVD_READ;
    rd_view[`LPA_T4] = `LPA_T4_READ;
  end

  // Expansion view carries only the page-received bit
  always @*
  begin
    xpn_view = `RDATA_IDLE;
    xpn_view[`XPN_PAGE_RX] = page_received;
  end

  // Read data stand for one cycle and then fall back to zero
  always @*
  begin
    rdata_nxt = `RDATA_IDLE;
    if (lpa_read)
    begin
      rdata_nxt = rd_view;
    end
    else if (xpn_read)
    begin
      rdata_nxt = xpn_view;
    end
  end

  // Decode looks at the stored selector, never at a word still arriving
  always @*
  begin
    sel_kind_nxt = sel_decode(lpa_r[`LPA_SEL_HI:`LPA_SEL_LO]);
  end

  // Registered so read data never follow the address combinationally
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rdata_r <= `RDATA_IDLE;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  // Decode is registered, so it trails a new word by one more cycle
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      sel_kind_r <= `SEL_NONE;
    end
    else
    begin
      sel_kind_r <= sel_kind_nxt;
    end
  end

  // Data outputs come straight from flip-flops; the support flag is a plain compare
  assign mgmt_rdata = rdata_r;
  assign selector_kind = sel_kind_r;
  assign selector_supported = (sel_kind_r == `SEL_IS_8023);

  // Flag set wins over the clearing read when both fall in one cycle
  page_flag u_page_flag
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .set_pulse(word_stored),
    .clr_pulse(xpn_read),
    .flag_r(page_received)
  );
endmodule // lp_ability_reg

// file: inc/lp_ability_defines.vh
// Constants of the link partner ability register
`ifndef LP_ABILITY_DEFINES_VH
`define LP_ABILITY_DEFINES_VH
`define LPA_ADDR 5'h05
`define XPN_ADDR 5'h06
`define LPA_RESET 16'h0000
`define LPA_NEXT_PAGE 15
`define LPA_ACK 14
`define LPA_REMOTE_FAULT 13
`define LPA_RSVD_HI 12
`define LPA_RSVD_LO 10
`define LPA_T4 9
`define LPA_TAF_HI 8
`define LPA_TAF_LO 5
`define LPA_SEL_HI 4
`define LPA_SEL_LO 0
`define LPA_SEL_CW_HI 3
`define LPA_RO_MASK 16'hFFF0
`define LPA_CW_MASK 16'h000F
`define LPA_ZERO_MASK 16'h1E00
`define SEL_8023 5'h01
`define SEL_8029 5'h02
`define SEL_NONE 2'h0
`define SEL_IS_8023 2'h1
`define SEL_IS_8029 2'h2
`define RDATA_IDLE 16'h0000
`define XPN_PAGE_RX 1
`define LPA_RSVD_READ 3'h0
`define LPA_T4_READ 1'h0
`endif

// file: hw/page_flag.v
// Latching-high page-received flag, set wins over read clear
module page_flag
(
  input wire clk_sys,
  input wire rst_b,
  input wire set_pulse,
  input wire clr_pulse,
  output reg flag_r
);
  always @(posedge clk_sys)
  begin
    if (!rst_b)
      flag_r <= 1'b0;
    else if (set_pulse)
      flag_r <= 1'b1;
    else if (clr_pulse)
      flag_r <= 1'b0;
  end
endmodule // page_flag

// file: testbench/lp_ability_reg_monitor.sv
// Port assertions for the ability register
module lp_ability_reg_monitor (input wire clk_sys, rst_b, rx_word_valid, override_writable,
  mgmt_rd, mgmt_wr, page_received, selector_supported, input wire [15:0] rx_word, mgmt_wdata,
  mgmt_rdata, input wire [4:0] mgmt_addr, input wire [1:0] selector_kind);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_RSV: assert property (mgmt_rdata[12:9] == 4'h0) else $error("bits 12:9 set");
  AST_LOAD: assert property (rx_word_valid ##1 mgmt_rd && mgmt_addr == 5'h05 && !rx_word_valid |=>
    mgmt_rdata == ($past(rx_word, 2) & 16'hE1FF)) else $error("word not loaded");
  AST_PG: assert property (rx_word_valid |=> page_received) else $error("flag not set");
  AST_XCLR: assert property (mgmt_rd && mgmt_addr == 5'h06 && !rx_word_valid |=> !page_received)
    else $error("flag not cleared");
  AST_XRD: assert property (mgmt_rd && mgmt_addr == 5'h06 |=> mgmt_rdata[1] == $past(page_received))
    else $error("flag read wrong");
  AST_SEL: assert property (rx_word_valid && rx_word[4:0] == 5'h01 ##1 !rx_word_valid && !mgmt_wr
    |=> selector_kind == 2'h1) else $error("selector decode");
  AST_SUP: assert property (selector_supported == (selector_kind == 2'h1)) else $error("support");
  AST_IDLE: assert property (!$past(mgmt_rd) |-> mgmt_rdata == 16'h0000) else $error("rdata held");
  cover property (rx_word_valid ##1 mgmt_rd);
  cover property (mgmt_wr && override_writable);
  cover property (mgmt_rd && mgmt_addr == 5'h06 && page_received);
endmodule // lp_ability_reg_monitor

// file: testbench/link_partner_model.sv
// Far side: hands over received capability words
module link_partner_model (input wire clk_sys, output logic [15:0] rx_word = 16'h0000,
  output logic rx_word_valid = 1'b0);
  timeunit 1ns;
  timeprecision 1ns;
  task send(input logic [15:0] w);
    @(negedge clk_sys); rx_word = w; rx_word_valid = 1'b1;
    @(negedge clk_sys); rx_word_valid = 1'b0; rx_word = ~w;
  endtask
endmodule // link_partner_model

// file: testbench/lp_ability_reg_test.sv
// Self-checking bench for the ability register
module lp_ability_reg_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst_b = 0, override_writable = 0, mgmt_rd = 0, mgmt_wr = 0;
  logic [4:0] mgmt_addr = 5'h00;
  logic [15:0] mgmt_wdata = 16'h0000;
  wire [15:0] mgmt_rdata, rx_word;
  wire rx_word_valid, page_received, selector_supported;
  wire [1:0] selector_kind;
  int error_cnt = 0, checked = 0;
  lp_ability_reg i_lp_ability_reg
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .rx_word(rx_word),
    .rx_word_valid(rx_word_valid),
    .override_writable(override_writable),
    .mgmt_addr(mgmt_addr),
    .mgmt_rd(mgmt_rd),
    .mgmt_wr(mgmt_wr),
    .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata),
    .page_received(page_received),
    .selector_kind(selector_kind),
    .selector_supported(selector_supported)
  );
  link_partner_model i_link_partner_model
  (
    .clk_sys(clk_sys),
    .rx_word(rx_word),
    .rx_word_valid(rx_word_valid)
  );
  task chk(input logic [15:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rd(input logic [4:0] a, input logic [15:0] exp);
    @(negedge clk_sys); mgmt_addr = a; mgmt_rd = 1;
    @(negedge clk_sys); mgmt_rd = 0; chk(mgmt_rdata, exp);
  endtask
  task wr(input logic [15:0] d);
    @(negedge clk_sys); mgmt_addr = 5'h05; mgmt_wdata = d; mgmt_wr = 1;
    @(negedge clk_sys); mgmt_wr = 0;
  endtask
  task stop_test;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial forever #5 clk_sys = ~clk_sys;
  initial
  begin
    repeat (12) @(negedge clk_sys); rst_b = 1;
    rd(5'h05, 16'h0000);
    i_link_partner_model.send(16'hFFFF);
    rd(5'h05, 16'hE1FF);
    rd(5'h06, 16'h0002);
    rd(5'h06, 16'h0000);
    wr(16'h0000);
    rd(5'h05, 16'hE1FF);
    override_writable = 1; wr(16'h0001);
    rd(5'h05, 16'hE1F1);
    rd(5'h07, 16'h0000);
    for (int c = 1; c < 4; c++)
    begin
      i_link_partner_model.send({11'h000, c[4:0]}); @(negedge clk_sys);
      chk({14'h0, selector_kind}, (c == 3) ? 16'h0000 : 16'(c));
      chk({15'h0, selector_supported}, {15'h0, c == 1});
    end
    fork
      i_link_partner_model.send(16'h5A3C);
      begin
        @(negedge clk_sys);
        rd(5'h05, 16'h403C);
      end
    join
    chk({15'h0, page_received}, 16'h0001);
    fork
      i_link_partner_model.send(16'h8001);
      wr(16'h000E);
    join
    rd(5'h05, 16'h8001);
    wr(16'h001F);
    rd(5'h05, 16'h800F);
    fork
      i_link_partner_model.send(16'h4021);
      rd(5'h06, 16'h0002);
    join
    rd(5'h06, 16'h0002);
    rd(5'h06, 16'h0000);
    rd(5'h05, 16'h4021);
    i_link_partner_model.send(16'h2001);
    @(negedge clk_sys);
    rst_b = 0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1;
    chk({15'h0, page_received}, 16'h0000);
    chk({14'h0, selector_kind}, 16'h0000);
    chk({15'h0, selector_supported}, 16'h0000);
    rd(5'h05, 16'h0000);
    stop_test;
  end
endmodule // lp_ability_reg_test
bind lp_ability_reg lp_ability_reg_monitor i_lp_ability_reg_monitor
(
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .rx_word_valid(rx_word_valid),
  .override_writable(override_writable),
  .mgmt_rd(mgmt_rd),
  .mgmt_wr(mgmt_wr),
  .page_received(page_received),
  .selector_supported(selector_supported),
  .rx_word(rx_word),
  .mgmt_wdata(mgmt_wdata),
  .mgmt_rdata(mgmt_rdata),
  .mgmt_addr(mgmt_addr),
  .selector_kind(selector_kind)
);
